//--- rtl/masu_pkg.sv
// package: shared constants and types for the capacity-limit security command block
// Contract
// [RULE1] host puts address bits 24-27 in head nibble
// [RULE2] device returns bits 0-7 or sector 63
// [RULE3] device returns bits 8-23 or cylinder
// [RULE4] device returns bits 24-27 or max head
// [RULE5] feature 01h selects set password
// [RULE6] feature 02h selects lock
// [RULE7] feature 03h selects unlock
// [RULE8] after native-max read, opcode sets max address; code updates max_lba in lba mode only, chs leaves it unchanged
// [RULE9] set password takes one 512-byte sector
// [RULE10] password kept until power cycle; accept when unlocked
// [RULE11] lock rejects all but unlock and freeze
// [RULE12] locked until unlock, freeze or power cycle
// [RULE13] unlock takes sector, compares stored password
// [RULE14] mismatch aborts, decrements counter from 5
// [RULE15] counter zero rejects unlock until reset
// [RULE16] match unlocks and accepts all commands
// [RULE17] feature 04h freezes, rejecting all later commands
// [RULE18] no native read: feature selects subcommand
// [RULE19] set max aborted when locked or frozen
// [RULE20] abort sets abort and error bits only
package masu_pkg;
    // ==========================================
    // command codes
    localparam logic [7:0] OPC_SET_MAX = 8'hf9;
    localparam logic [7:0] OPC_READ_NATIVE = 8'hf8;
    localparam logic [7:0] FEAT_SET_PW = 8'h01;
    localparam logic [7:0] FEAT_LOCK = 8'h02;
    localparam logic [7:0] FEAT_UNLOCK = 8'h03;
    localparam logic [7:0] FEAT_FREEZE = 8'h04;
    // ==========================================
    // sector layout in 16-bit words
    localparam int SECTOR_WORDS = 256;
    localparam logic [7:0] PW_FIRST_WORD = 8'h01;
    localparam logic [7:0] PW_LAST_WORD = 8'h10;
    localparam int PW_WORDS = 16;
    // ==========================================
    // register bits
    localparam int ERR_ABORT_BIT = 2;
    localparam int STS_BUSY_BIT = 7;
    localparam int STS_READY_BIT = 6;
    localparam int STS_SEEK_BIT = 4;
    localparam int STS_DRQ_BIT = 3;
    localparam int STS_ERR_BIT = 0;
    localparam int DEVHEAD_LBA_BIT = 6;
    localparam logic [2:0] UNLOCK_TRIES_RESET = 3'h5;
    localparam logic [7:0] CHS_MAX_SECTOR = 8'h3f;
    // ==========================================
    // default capacity, arbitrary plain values
    localparam logic [27:0] NATIVE_MAX_LBA = 28'h0ffffff;
    localparam logic [15:0] CHS_MAX_CYL = 16'h3fff;
    localparam logic [3:0] CHS_MAX_HEAD = 4'hf;
    // ==========================================
    // host-side register map over apb (byte addresses)
    localparam logic [7:0] HREG_CMD = 8'h00;
    localparam logic [7:0] HREG_ADDR = 8'h04;
    localparam logic [7:0] HREG_PW_IDX = 8'h08;
    localparam logic [7:0] HREG_PW_DATA = 8'h0c;
    localparam logic [7:0] HREG_STATUS = 8'h10;
    localparam logic [7:0] HREG_RESULT = 8'h14;
    localparam int HCMD_GO_BIT = 31;

    typedef enum logic [1:0] {
        MASU_UNLOCKED = 2'b00,
        MASU_LOCKED = 2'b01,
        MASU_FROZEN = 2'b10
    } masu_lock_t;
endpackage

//--- rtl/masu_if.sv
// interface: command block, data-out sector words and completion between host and device
`timescale 1ns/10ps
`default_nettype none
interface masu_if;
    logic cmd_valid;
    logic [7:0] cmd_opcode;
    logic [7:0] cmd_feature;
    logic [7:0] cmd_sector;
    logic [7:0] cmd_cyl_low;
    logic [7:0] cmd_cyl_high;
    logic [7:0] cmd_dev_head;
    logic data_valid;
    logic [15:0] data_word;
    logic data_request_flag;
    logic done;
    logic [7:0] error_flags;
    logic [7:0] status_flags;
    logic [7:0] ret_sector;
    logic [7:0] ret_cyl_low;
    logic [7:0] ret_cyl_high;
    logic [7:0] ret_dev_head;

    modport host (
        output cmd_valid, cmd_opcode, cmd_feature, cmd_sector, cmd_cyl_low, cmd_cyl_high, cmd_dev_head,
        output data_valid, data_word,
        input data_request_flag, done, error_flags, status_flags, ret_sector, ret_cyl_low, ret_cyl_high, ret_dev_head
    );
    modport dev (
        input cmd_valid, cmd_opcode, cmd_feature, cmd_sector, cmd_cyl_low, cmd_cyl_high, cmd_dev_head,
        input data_valid, data_word,
        output data_request_flag, done, error_flags, status_flags, ret_sector, ret_cyl_low, ret_cyl_high, ret_dev_head
    );
endinterface
`default_nettype wire

//--- rtl/masu_device.sv
// device end: decodes the capacity-limit opcode and runs the lock state machine
`timescale 1ns/10ps
`default_nettype none
module masu_device
    import masu_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    masu_if.dev bus,
    output logic [1:0] o_lock_state,
    output logic [2:0] o_unlock_tries,
    output logic [27:0] o_max_lba
);
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_DATA = 2'b01
    } masu_dstate_t;

    masu_dstate_t state;
    masu_lock_t lock;
    logic [7:0] sub;
    logic [7:0] word_idx;
    logic [15:0] pw_store [PW_WORDS];
    logic pw_mismatch;
    logic prev_native;
    logic [2:0] tries;
    logic [27:0] max_lba;
    logic word_in_pw;

    assign word_in_pw = (word_idx >= PW_FIRST_WORD) && (word_idx <= PW_LAST_WORD);
    assign o_lock_state = lock;
    assign o_unlock_tries = tries;
    assign o_max_lba = max_lba;

    // ==========================================
    // command acceptance and sector collection
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= DEV_IDLE;
            sub <= 8'h00;
            word_idx <= 8'h00;
            bus.data_request_flag <= 1'b0;
        end else begin
            unique case (state)
                DEV_IDLE: begin
                    // only data-carrying subcommands that will not be refused open a sector
                    if (bus.cmd_valid && bus.cmd_opcode == OPC_SET_MAX && !prev_native) begin // [RULE18]
                        if ((bus.cmd_feature == FEAT_SET_PW && lock == MASU_UNLOCKED) // [RULE9] [RULE10]
                            || (bus.cmd_feature == FEAT_UNLOCK && lock == MASU_LOCKED
                                && tries != 3'h0)) begin // [RULE13] [RULE15]
                            state <= DEV_DATA;
                            sub <= bus.cmd_feature;
                            word_idx <= 8'h00;
                            bus.data_request_flag <= 1'b1;
                        end
                    end
                end
                DEV_DATA: begin
                    if (bus.data_valid) begin
                        word_idx <= word_idx + 8'h01;
                        if (word_idx == 8'(SECTOR_WORDS - 1)) begin
                            state <= DEV_IDLE;
                            bus.data_request_flag <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================
    // password words, kept across everything but reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < PW_WORDS; i++) begin
                pw_store[i] <= 16'h0000;
            end
        end else if (state == DEV_DATA && bus.data_valid && word_in_pw && sub == FEAT_SET_PW) begin
            pw_store[4'(word_idx - PW_FIRST_WORD)] <= bus.data_word; // [RULE9] [RULE10]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pw_mismatch <= 1'b0;
        end else if (state == DEV_IDLE) begin
            pw_mismatch <= 1'b0;
        end else if (bus.data_valid && word_in_pw && sub == FEAT_UNLOCK
                     && pw_store[4'(word_idx - PW_FIRST_WORD)] != bus.data_word) begin
            pw_mismatch <= 1'b1; // [RULE13]
        end
    end

    // ==========================================
    // completion: lock state, counter, returned registers
    logic last_word;
    logic mismatch_final;
    assign last_word = state == DEV_DATA && bus.data_valid && word_idx == 8'(SECTOR_WORDS - 1);
    assign mismatch_final = pw_mismatch;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock <= MASU_UNLOCKED;
            tries <= UNLOCK_TRIES_RESET;
            prev_native <= 1'b0;
            max_lba <= NATIVE_MAX_LBA;
            bus.done <= 1'b0;
            bus.error_flags <= 8'h00;
            bus.status_flags <= 8'h50;
            bus.ret_sector <= 8'h00;
            bus.ret_cyl_low <= 8'h00;
            bus.ret_cyl_high <= 8'h00;
            bus.ret_dev_head <= 8'h00;
        end else begin
            bus.done <= 1'b0;
            if (state == DEV_IDLE && bus.cmd_valid) begin
                prev_native <= bus.cmd_opcode == OPC_READ_NATIVE;
            end
            // a native-max read ends at once; the host stays busy until done
            if (state == DEV_IDLE && bus.cmd_valid && bus.cmd_opcode != OPC_SET_MAX) begin
                bus.done <= 1'b1;
                bus.error_flags <= 8'h00;
                bus.status_flags <= 8'h50;
            end
            if (state == DEV_IDLE && bus.cmd_valid && bus.cmd_opcode == OPC_SET_MAX) begin
                logic abort;
                abort = 1'b0;
                if (prev_native) begin // [RULE8]
                    if (lock != MASU_UNLOCKED) begin
                        abort = 1'b1; // [RULE19]
                    end else if (bus.cmd_dev_head[DEVHEAD_LBA_BIT]) begin
                        max_lba <= {bus.cmd_dev_head[3:0], bus.cmd_cyl_high,
                                    bus.cmd_cyl_low, bus.cmd_sector}; // [RULE1]
                        bus.ret_sector <= bus.cmd_sector; // [RULE2]
                        bus.ret_cyl_low <= bus.cmd_cyl_low; // [RULE3]
                        bus.ret_cyl_high <= bus.cmd_cyl_high;
                        bus.ret_dev_head <= {4'h0, bus.cmd_dev_head[3:0]}; // [RULE4]
                    end else begin
                        // chs: head nibble ignored on input
                        bus.ret_sector <= CHS_MAX_SECTOR; // [RULE2]
                        bus.ret_cyl_low <= bus.cmd_cyl_low; // [RULE3]
                        bus.ret_cyl_high <= bus.cmd_cyl_high;
                        bus.ret_dev_head <= {4'h0, CHS_MAX_HEAD}; // [RULE4]
                    end
                end else begin
                    unique case (bus.cmd_feature)
                        FEAT_SET_PW: abort = lock != MASU_UNLOCKED; // [RULE5] [RULE11]
                        FEAT_LOCK: begin // [RULE6]
                            if (lock == MASU_UNLOCKED) begin
                                lock <= MASU_LOCKED; // [RULE11] [RULE12]
                            end else begin
                                abort = 1'b1;
                            end
                        end
                        FEAT_UNLOCK: abort = lock != MASU_LOCKED || tries == 3'h0; // [RULE7] [RULE15]
                        FEAT_FREEZE: begin
                            if (lock == MASU_FROZEN) begin
                                abort = 1'b1; // [RULE17]
                            end else begin
                                lock <= MASU_FROZEN; // [RULE17] [RULE12]
                            end
                        end
                        default: abort = 1'b1;
                    endcase
                end
                // data-carrying subcommands complete at their last word
                if (abort || prev_native
                    || (bus.cmd_feature != FEAT_SET_PW && bus.cmd_feature != FEAT_UNLOCK)) begin
                    bus.done <= 1'b1;
                    bus.error_flags <= abort ? 8'h04 : 8'h00; // [RULE20]
                    bus.status_flags <= abort ? 8'h51 : 8'h50;
                end
            end
            if (last_word) begin
                logic fail;
                fail = sub == FEAT_UNLOCK && (mismatch_final || (word_in_pw
                        && pw_store[4'(word_idx - PW_FIRST_WORD)] != bus.data_word));
                if (sub == FEAT_UNLOCK) begin
                    if (fail) begin
                        tries <= tries - 3'h1; // [RULE14]
                    end else begin
                        lock <= MASU_UNLOCKED; // [RULE16] [RULE12]
                    end
                end
                bus.done <= 1'b1;
                bus.error_flags <= fail ? 8'h04 : 8'h00; // [RULE14] [RULE20]
                bus.status_flags <= fail ? 8'h51 : 8'h50;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/masu_host.sv
// host end: apb-programmed issuer of capacity-limit commands and password sectors
`timescale 1ns/10ps
`default_nettype none
module masu_host
    import masu_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    masu_if.host bus
);
    logic [31:0] cmd_reg;
    logic [31:0] addr_reg;
    logic [3:0] pw_idx;
    logic [15:0] pw_buf [PW_WORDS];
    logic busy;
    logic sending;
    logic [7:0] word_idx;
    logic sector_sent;
    logic [31:0] result;
    logic wr;
    logic rd;

    assign o_pready = 1'b1;
    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && !i_penable && !i_pwrite;
    assign o_pslverr = 1'b0;

    // ==========================================
    // apb registers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_reg <= 32'h00000000;
            addr_reg <= 32'h00000000;
            pw_idx <= 4'h0;
        end else if (wr) begin
            unique case (i_paddr)
                HREG_CMD: cmd_reg <= i_pwdata;
                HREG_ADDR: addr_reg <= i_pwdata;
                HREG_PW_IDX: pw_idx <= i_pwdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < PW_WORDS; i++) begin
                pw_buf[i] <= 16'h0000;
            end
        end else if (wr && i_paddr == HREG_PW_DATA) begin
            pw_buf[pw_idx] <= i_pwdata[15:0];
        end
    end

    // read data registered in setup so the access cycle sees it
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (rd) begin
            unique case (i_paddr)
                HREG_CMD: o_prdata <= cmd_reg;
                HREG_ADDR: o_prdata <= addr_reg;
                HREG_PW_IDX: o_prdata <= {28'h0, pw_idx};
                HREG_PW_DATA: o_prdata <= {16'h0, pw_buf[pw_idx]};
                HREG_STATUS: o_prdata <= {30'h0, sending, busy};
                HREG_RESULT: o_prdata <= result;
                default: o_prdata <= 32'h00000000;
            endcase
        end
    end

    // ==========================================
    // issuing: go bit in command word starts one command
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy <= 1'b0;
            sending <= 1'b0;
            word_idx <= 8'h00;
            sector_sent <= 1'b0;
            result <= 32'h00000000;
            bus.cmd_valid <= 1'b0;
            bus.cmd_opcode <= 8'h00;
            bus.cmd_feature <= 8'h00;
            bus.cmd_sector <= 8'h00;
            bus.cmd_cyl_low <= 8'h00;
            bus.cmd_cyl_high <= 8'h00;
            bus.cmd_dev_head <= 8'h00;
            bus.data_valid <= 1'b0;
            bus.data_word <= 16'h0000;
        end else begin
            bus.cmd_valid <= 1'b0;
            bus.data_valid <= 1'b0;
            if (wr && i_paddr == HREG_CMD && i_pwdata[HCMD_GO_BIT] && !busy) begin
                busy <= 1'b1;
                bus.cmd_valid <= 1'b1;
                bus.cmd_opcode <= i_pwdata[7:0];
                bus.cmd_feature <= i_pwdata[15:8]; // [RULE5] [RULE6] [RULE7] [RULE17]
                bus.cmd_sector <= addr_reg[7:0];
                bus.cmd_cyl_low <= addr_reg[15:8];
                bus.cmd_cyl_high <= addr_reg[23:16];
                bus.cmd_dev_head <= {1'b1, i_pwdata[16], 2'b10, addr_reg[27:24]}; // [RULE1]
            end
            // drq falls one cycle after the last word, so stop on our own count
            if (busy && bus.data_request_flag && !bus.done && !sector_sent) begin
                // one word per cycle; words outside the password are reserved zero
                sending <= 1'b1;
                bus.data_valid <= 1'b1; // [RULE9] [RULE13]
                bus.data_word <= (word_idx >= PW_FIRST_WORD && word_idx <= PW_LAST_WORD)
                    ? pw_buf[4'(word_idx - PW_FIRST_WORD)] : 16'h0000;
                word_idx <= word_idx + 8'h01;
                if (word_idx == 8'(SECTOR_WORDS - 1)) begin
                    sending <= 1'b0;
                    sector_sent <= 1'b1;
                end
            end
            if (bus.done) begin
                busy <= 1'b0;
                sending <= 1'b0;
                sector_sent <= 1'b0;
                word_idx <= 8'h00;
                result <= {bus.status_flags, bus.error_flags, 4'h0, bus.ret_dev_head[3:0],
                           bus.ret_cyl_high};
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/masu_assertions.sv
// checker: link-level properties between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
module masu_assertions
    import masu_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] cmd_feature,
    input wire logic [7:0] cmd_sector,
    input wire logic [7:0] cmd_cyl_low,
    input wire logic [7:0] cmd_cyl_high,
    input wire logic [7:0] cmd_dev_head,
    input wire logic data_valid,
    input wire logic data_request_flag,
    input wire logic done,
    input wire logic [7:0] error_flags,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] ret_sector,
    input wire logic [7:0] ret_cyl_low,
    input wire logic [7:0] ret_cyl_high,
    input wire logic [7:0] ret_dev_head
);
    // ==========================================
    // helper state
    logic cur_nat;
    logic was_nat;
    logic seen_drq;
    logic [8:0] word_cnt;

    // was_nat holds whether the command before the current one was a native-max read
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_nat <= 1'b0;
            was_nat <= 1'b0;
        end else if (cmd_valid) begin
            was_nat <= cur_nat;
            cur_nat <= (cmd_opcode == OPC_READ_NATIVE);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_drq <= 1'b0;
            word_cnt <= 9'h0;
        end else if (cmd_valid) begin
            seen_drq <= 1'b0;
            word_cnt <= 9'h0;
        end else begin
            if (data_request_flag) seen_drq <= 1'b1;
            if (data_valid) word_cnt <= word_cnt + 9'h1;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    abort_flags_a: assert property (done && error_flags[ERR_ABORT_BIT]
        |-> error_flags == 8'h04 && status_flags == 8'h51) else $error("abort completion flags wrong");
    good_flags_a: assert property (done && !error_flags[ERR_ABORT_BIT]
        |-> error_flags == 8'h00 && status_flags == 8'h50) else $error("good completion flags wrong");
    drq_cause_a: assert property ($rose(data_request_flag) |-> $past(cmd_valid) && !was_nat
        && $past(cmd_opcode) == OPC_SET_MAX && ($past(cmd_feature) == FEAT_SET_PW
        || $past(cmd_feature) == FEAT_UNLOCK)) else $error("sector request without password subcommand");
    sector_len_a: assert property (done && seen_drq |-> word_cnt == 9'h100)
        else $error("sector not 256 words");
    word_drq_a: assert property (data_valid |-> data_request_flag) else $error("word sent outside data phase");
    lba_ret_a: assert property (done && cmd_opcode == OPC_SET_MAX && was_nat
        && !error_flags[ERR_ABORT_BIT] && cmd_dev_head[6] |-> ret_sector == cmd_sector
        && ret_cyl_low == cmd_cyl_low && ret_cyl_high == cmd_cyl_high
        && ret_dev_head[3:0] == cmd_dev_head[3:0]) else $error("lba return registers wrong");
    chs_ret_a: assert property (done && cmd_opcode == OPC_SET_MAX && was_nat
        && !error_flags[ERR_ABORT_BIT] && !cmd_dev_head[6] |-> ret_sector == 8'h3f
        && ret_dev_head[3:0] == CHS_MAX_HEAD && {ret_cyl_high, ret_cyl_low} == {cmd_cyl_high, cmd_cyl_low})
        else $error("chs return registers wrong");
    plain_max_a: assert property (cmd_valid && cmd_opcode == OPC_SET_MAX && cur_nat
        |-> !data_request_flag throughout (##[1:4] done)) else $error("set max after native read misdecoded");
    nodata_sub_a: assert property (cmd_valid && cmd_opcode == OPC_SET_MAX && !cur_nat
        && (cmd_feature == FEAT_LOCK || cmd_feature == FEAT_FREEZE) |-> ##1 !data_request_flag [*3])
        else $error("lock or freeze asked for a sector");

    sector_c: cover property (done && seen_drq);
    abort_c: cover property (done && error_flags[ERR_ABORT_BIT]);
    plain_c: cover property (cmd_valid && cmd_opcode == OPC_SET_MAX && cur_nat);
endmodule
`default_nettype wire

//--- bench/tb.sv
// testbench: apb-driven host end facing the device end across the interface
`timescale 1ns/10ps
`default_nettype none
module tb;
    import masu_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] lock_state;
    logic [2:0] tries;
    logic [27:0] max_lba;
    int err_count, compares;

    masu_if link();
    masu_host masu_host_inst(.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .bus(link));
    masu_device masu_device_inst(.i_ref_clk(clk), .i_rst_n(rst_n), .bus(link), .o_lock_state(lock_state),
        .o_unlock_tries(tries), .o_max_lba(max_lba));
    masu_assertions masu_assertions_inst(.i_ref_clk(clk), .i_rst_n(rst_n), .cmd_valid(link.cmd_valid),
        .cmd_opcode(link.cmd_opcode), .cmd_feature(link.cmd_feature), .cmd_sector(link.cmd_sector),
        .cmd_cyl_low(link.cmd_cyl_low), .cmd_cyl_high(link.cmd_cyl_high), .cmd_dev_head(link.cmd_dev_head),
        .data_valid(link.data_valid), .data_request_flag(link.data_request_flag), .done(link.done), .error_flags(link.error_flags),
        .status_flags(link.status_flags), .ret_sector(link.ret_sector), .ret_cyl_low(link.ret_cyl_low),
        .ret_cyl_high(link.ret_cyl_high), .ret_dev_head(link.ret_dev_head));

    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one idle edge first, so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pw(input logic [15:0] base);
        for (int i = 0; i < PW_WORDS; i++) begin
            apb(1'b1, HREG_PW_IDX, 32'(i));
            apb(1'b1, HREG_PW_DATA, {16'h0, base + 16'(i)});
        end
    endtask

    // md: 0 expect success, 1 expect abort, 2 leave unjudged
    task automatic issue(input logic [7:0] op, input logic [7:0] ft, input logic lba, input int md);
        logic [15:0] exp;
        apb(1'b1, HREG_CMD, {1'b1, 14'h0, lba, ft, op});
        rd = 32'h1;
        for (int n = 0; n < 400 && rd[0] !== 1'b0; n++) begin
            apb(1'b0, HREG_STATUS, 32'h0);
        end
        chk({31'h0, rd[0]}, 32'h0, "command never completed");
        apb(1'b0, HREG_RESULT, 32'h0);
        exp = (md == 1) ? 16'h5104 : 16'h5000;
        if (md != 2) begin
            chk({link.status_flags, link.error_flags, rd[31:16]}, {exp, exp}, "completion flags");
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk({lock_state, tries}, {MASU_UNLOCKED, 3'h5}, "state after reset");
        chk(max_lba, NATIVE_MAX_LBA, "max after reset");
        chk(link.status_flags, 8'h50, "status after reset");
    endtask

    task automatic t_lock();
        pw(16'h1200);
        issue(OPC_SET_MAX, FEAT_SET_PW, 1'b1, 0);
        issue(OPC_SET_MAX, FEAT_LOCK, 1'b1, 0);
        chk(lock_state, MASU_LOCKED, "lock entered");
        issue(OPC_SET_MAX, FEAT_SET_PW, 1'b1, 1);
        issue(OPC_SET_MAX, FEAT_LOCK, 1'b1, 1);
        issue(OPC_READ_NATIVE, 8'h00, 1'b1, 2);
        issue(OPC_SET_MAX, 8'h00, 1'b1, 1);
        chk({lock_state, max_lba}, {MASU_LOCKED, NATIVE_MAX_LBA}, "locked state kept");
    endtask

    task automatic t_unlock();
        pw(16'h3400);
        issue(OPC_SET_MAX, FEAT_UNLOCK, 1'b1, 1);
        chk({lock_state, tries}, {MASU_LOCKED, 3'h4}, "one mismatch");
        pw(16'h1200);
        issue(OPC_SET_MAX, FEAT_UNLOCK, 1'b1, 0);
        chk(lock_state, MASU_UNLOCKED, "unlocked by match");
        issue(OPC_SET_MAX, FEAT_SET_PW, 1'b1, 0);
    endtask

    task automatic t_setmax();
        apb(1'b1, HREG_ADDR, 32'h00a5c3e1);
        issue(OPC_READ_NATIVE, 8'h00, 1'b1, 0);
        issue(OPC_SET_MAX, FEAT_LOCK, 1'b1, 0);
        chk({link.cmd_dev_head[6], link.cmd_dev_head[3:0]}, 5'h10, "lba head nibble sent");
        chk({link.ret_dev_head[3:0], link.ret_cyl_high, link.ret_cyl_low, link.ret_sector},
            28'h0a5c3e1, "lba return");
        chk({lock_state, max_lba}, {MASU_UNLOCKED, 28'h0a5c3e1}, "plain set max");
        issue(OPC_READ_NATIVE, 8'h00, 1'b0, 0);
        issue(OPC_SET_MAX, 8'h00, 1'b0, 0);
        chk({link.ret_dev_head[3:0], link.ret_sector}, 12'hf3f, "chs return");
    endtask

    task automatic t_exhaust();
        issue(OPC_SET_MAX, FEAT_LOCK, 1'b1, 0);
        pw(16'h5600);
        repeat (5) issue(OPC_SET_MAX, FEAT_UNLOCK, 1'b1, 1);
        chk(tries, 3'h0, "tries spent");
        pw(16'h1200);
        issue(OPC_SET_MAX, FEAT_UNLOCK, 1'b1, 1);
        chk(lock_state, MASU_LOCKED, "unlock refused at zero");
    endtask

    task automatic t_freeze();
        issue(OPC_SET_MAX, FEAT_FREEZE, 1'b1, 0);
        chk(lock_state, MASU_FROZEN, "frozen from locked");
        issue(OPC_SET_MAX, FEAT_LOCK, 1'b1, 1);
        issue(OPC_SET_MAX, FEAT_SET_PW, 1'b1, 1);
        issue(OPC_READ_NATIVE, 8'h00, 1'b1, 2);
        issue(OPC_SET_MAX, 8'h00, 1'b1, 1);
    endtask

    // hard reset in mid-run restores the counter and the unlocked state
    task automatic t_rearm();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({lock_state, tries}, {MASU_UNLOCKED, 3'h5}, "state after hard reset");
        issue(OPC_SET_MAX, 8'h05, 1'b1, 1);
        issue(OPC_SET_MAX, FEAT_FREEZE, 1'b1, 0);
        chk(lock_state, MASU_FROZEN, "frozen from unlocked");
    endtask

    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lock();
        t_unlock();
        t_setmax();
        t_exhaust();
        t_freeze();
        t_rearm();
        results();
    end
endmodule
`default_nettype wire
